// [logic/fdc_perp_read_setup.sv]
`timescale 1ns/100ps
`include "fdc_setup_cfg.svh"

// How it works
// - Hardware reset clears all mode bits: every drive conventional.
// - The perpendicular-mode command is accepted whenever the engine is idle.
// - Nonzero group field rules all drives; else per-drive bits decide.
// - Group 10 conventional, 01 perpendicular 500K, 11 perpendicular 1-2M; 00 defers to per-drive bits.
// - Software reset clears the group field.
// - Per-drive bits 5-2 map to drives 3-0, applied if group zero and gated.
// - Per-drive bits survive software reset.
// - Gate bit 7 low leaves per-drive bits untouched.
// - Mode command only updates configuration and returns no result bytes.
// - Format gap 2 is 22 bytes, 41 for perpendicular at 1-2 Mbps.
// - Write rewrites 0, 19 or 38 bytes of gap 2 by mode and rate.
// - Perpendicular drives get zero precompensation at any rate.
// - Read-data opcode has low bits 00110 plus three flag bits.
// - Eight parameter bytes follow; last one, data length, is ignored.
// - After the last byte the engine waits the pre-processing delay.
// - Opcode bit 5 selects skipping of deleted sectors.
// - Opcode bit 6 selects double density encoding, else single.
// - Opcode bit 7 continues onto side 1 after side 0.
// - Drive codes 10 and 11 are valid only with enough drive support.
// - Head side output, active low, is the inverse of bit 2.
// - Drive/head bit 7 requests a seek pulse in the same cycle as the execute start.
module fdc_perp_read_setup #(
	parameter int unsigned PRE_DELAY_CYCLES = `FDC_PRE_DELAY_CYCLES
) (
	input  wire logic                    clk,
	input  wire logic                    reset_n,
	input  wire logic                    awvalid,
	output logic                         awready,
	input  wire logic [11:0]             awaddr,
	input  wire logic                    wvalid,
	output logic                         wready,
	input  wire logic [31:0]             wdata,
	input  wire logic [3:0]              wstrb,
	output logic                         bvalid,
	input  wire logic                    bready,
	output logic [1:0]                   bresp,
	input  wire logic                    arvalid,
	output logic                         arready,
	input  wire logic [11:0]             araddr,
	output logic                         rvalid,
	input  wire logic                    rready,
	output logic [31:0]                  rdata,
	output logic [1:0]                   rresp,
	output fdc_setup_pkg::readCmd_t      readCmd,
	output fdc_setup_pkg::gapInfo_t      gapInfo,
	output logic                         driveSelectValid,
	output logic                         headSideOutput_n,
	output logic                         executeStart,
	output logic                         seekStart
);

	if (PRE_DELAY_CYCLES < 1 || PRE_DELAY_CYCLES > 24'hffffff) begin : g_chk
		$error("PRE_DELAY_CYCLES out of range");
	end

	// Address decode shared by both bus directions; bit 3 marks a hit
	function automatic logic [3:0] decode(input logic [11:0] a);
		case (a)
			`FDC_OFF_CMD:    decode = 4'h8;
			`FDC_OFF_STATUS: decode = 4'h9;
			`FDC_OFF_MODE:   decode = 4'ha;
			`FDC_OFF_PARAM0: decode = 4'hb;
			`FDC_OFF_PARAM1: decode = 4'hc;
			`FDC_OFF_CTRL:   decode = 4'hd;
			`FDC_OFF_GAP:    decode = 4'he;
			default:         decode = 4'h0;
		endcase
	endfunction

	fdc_setup_pkg::cmdState_t state;
	logic [11:0] awAddrHeld;
	logic        awHeld;
	logic [31:0] wDataHeld;
	logic [3:0]  wStrbHeld;
	logic        wHeld;
	logic        wrFire;
	logic [3:0]  wrDec;
	logic        cmdWrite;
	logic        ctrlWrite;
	logic [7:0]  cmdByte;
	logic [3:0]  ctrlReg;
	logic        swReset;
	logic        clrErr;
	logic [1:0]  groupRecordingMode;
	logic [3:0]  perDriveRecordingMode;
	logic [2:0]  paramIdx;
	logic [23:0] delayCount;
	logic        invalidOpcode;
	logic        effPerp;
	logic        effHigh;
	logic        perpByte;

	assign wrDec     = decode(awAddrHeld);
	assign wrFire    = awHeld && wHeld && !bvalid;
	assign cmdWrite  = wrFire && wrDec == 4'h8 && wStrbHeld[0];
	assign ctrlWrite = wrFire && wrDec == 4'hd && wStrbHeld[0];
	assign cmdByte   = wDataHeld[7:0];
	assign swReset   = ctrlWrite && wDataHeld[`FDC_CTRL_SRST];
	assign clrErr    = ctrlWrite && wDataHeld[`FDC_CTRL_CLRERR];
	assign perpByte  = cmdWrite && state == fdc_setup_pkg::CMD_PERP_PARAM;

	// Write channels: address and data taken in either order
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			awready    <= 1'b1;
			wready     <= 1'b1;
			awHeld     <= 1'b0;
			wHeld      <= 1'b0;
			awAddrHeld <= 12'h000;
			wDataHeld  <= 32'h00000000;
			wStrbHeld  <= 4'h0;
			bvalid     <= 1'b0;
			bresp      <= `FDC_RESP_OKAY;
		end else begin
			if (awvalid && awready) begin
				awAddrHeld <= awaddr;
				awHeld     <= 1'b1;
				awready    <= 1'b0;
			end
			if (wvalid && wready) begin
				wDataHeld <= wdata;
				wStrbHeld <= wstrb;
				wHeld     <= 1'b1;
				wready    <= 1'b0;
			end
			if (wrFire) begin
				bvalid <= 1'b1;
				bresp  <= wrDec[3] ? `FDC_RESP_OKAY : `FDC_RESP_SLVERR;
				awHeld <= 1'b0;
				wHeld  <= 1'b0;
			end
			if (bvalid && bready) begin
				bvalid  <= 1'b0;
				awready <= 1'b1;
				wready  <= 1'b1;
			end
		end
	end

	// Read channel: answer one cycle after the address is taken
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			arready <= 1'b1;
			rvalid  <= 1'b0;
			rdata   <= 32'h00000000;
			rresp   <= `FDC_RESP_OKAY;
		end else if (arvalid && arready) begin
			arready <= 1'b0;
			rvalid  <= 1'b1;
			rresp   <= decode(araddr) == 4'h0 ? `FDC_RESP_SLVERR
				: `FDC_RESP_OKAY;
			case (decode(araddr))
				4'h9: rdata <= {25'h0, invalidOpcode, driveSelectValid,
					paramIdx, state == fdc_setup_pkg::CMD_PRE_DELAY,
					state != fdc_setup_pkg::CMD_IDLE};
				4'ha: rdata <= {25'h0, effPerp, perDriveRecordingMode,
					groupRecordingMode};
				4'hb: rdata <= {readCmd.sizeCode, readCmd.sector,
					readCmd.head, readCmd.track};
				4'hc: rdata <= {8'h0, readCmd.gap3,
					readCmd.finalSectorNumber,
					readCmd.continueToSecondSide,
					readCmd.doubleDensityEncoding,
					readCmd.skipDeletedSectors,
					readCmd.automaticSeekEnable, 1'b0,
					readCmd.headSideBit, readCmd.logicalDriveSelect};
				4'hd: rdata <= {28'h0, ctrlReg};
				4'he: rdata <= {18'h0, gapInfo.precompZero,
					gapInfo.perpendicular, gapInfo.rewriteLength,
					gapInfo.gap2Length};
				default: rdata <= 32'h00000000;
			endcase
		end else if (rvalid && rready) begin
			rvalid  <= 1'b0;
			arready <= 1'b1;
		end
	end

	// Data rate and drive support; reset pulses are not stored
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			ctrlReg <= `FDC_CTRL_RESET;
		else if (ctrlWrite)
			ctrlReg <= wDataHeld[3:0];
	end

	// Group field: cleared by either reset
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			groupRecordingMode <= 2'h0;
		else if (swReset)
			groupRecordingMode <= 2'h0;
		else if (perpByte)
			groupRecordingMode <= cmdByte[1:0];
	end

	// Per-drive bits: gated, and kept across software reset
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			perDriveRecordingMode <= 4'h0;
		else if (perpByte && !swReset && cmdByte[7]
			&& cmdByte[1:0] == 2'h0)
			perDriveRecordingMode <= cmdByte[5:2];
	end

	// Command sequencer
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state      <= fdc_setup_pkg::CMD_IDLE;
			paramIdx   <= 3'h0;
			delayCount <= 24'h000000;
		end else if (swReset) begin
			state    <= fdc_setup_pkg::CMD_IDLE;
			paramIdx <= 3'h0;
		end else begin
			case (state)
				fdc_setup_pkg::CMD_IDLE: begin
					paramIdx <= 3'h0;
					if (cmdWrite && cmdByte == `FDC_OP_PERP)
						state <= fdc_setup_pkg::CMD_PERP_PARAM;
					else if (cmdWrite && cmdByte[4:0] == `FDC_OP_READ)
						state <= fdc_setup_pkg::CMD_READ_PARAM;
				end
				fdc_setup_pkg::CMD_PERP_PARAM:
					if (cmdWrite)
						state <= fdc_setup_pkg::CMD_IDLE;
				fdc_setup_pkg::CMD_READ_PARAM:
					if (cmdWrite) begin
						paramIdx <= paramIdx + 3'h1;
						if (paramIdx == `FDC_LAST_PARAM) begin
							state      <= fdc_setup_pkg::CMD_PRE_DELAY;
							delayCount <= 24'(PRE_DELAY_CYCLES - 1);
						end
					end
				fdc_setup_pkg::CMD_PRE_DELAY:
					if (delayCount == 24'h000000)
						state <= fdc_setup_pkg::CMD_IDLE;
					else
						delayCount <= delayCount - 24'h000001;
				default: state <= fdc_setup_pkg::CMD_IDLE;
			endcase
		end
	end

	// Start pulses at the end of the delay; seek only if requested
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			executeStart <= 1'b0;
			seekStart    <= 1'b0;
		end else begin
			executeStart <= !swReset && delayCount == 24'h000000
				&& state == fdc_setup_pkg::CMD_PRE_DELAY;
			seekStart <= !swReset && delayCount == 24'h000000
				&& state == fdc_setup_pkg::CMD_PRE_DELAY
				&& readCmd.automaticSeekEnable;
		end
	end

	// Captured read-data command; data length byte is dropped
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			readCmd          <= '0;
			headSideOutput_n <= 1'b1;
			driveSelectValid <= 1'b1;
		end else if (cmdWrite && !swReset) begin
			if (state == fdc_setup_pkg::CMD_IDLE
				&& cmdByte[4:0] == `FDC_OP_READ) begin
				readCmd.continueToSecondSide  <= cmdByte[7];
				readCmd.doubleDensityEncoding <= cmdByte[6];
				readCmd.skipDeletedSectors    <= cmdByte[5];
			end else if (state == fdc_setup_pkg::CMD_READ_PARAM) begin
				case (paramIdx)
					3'h0: begin
						readCmd.automaticSeekEnable <= cmdByte[7];
						readCmd.headSideBit         <= cmdByte[2];
						readCmd.logicalDriveSelect  <= cmdByte[1:0];
						headSideOutput_n <= !cmdByte[2];
						// Codes 10 and 11 need drive support
						driveSelectValid <= !cmdByte[1]
							|| ctrlReg[`FDC_CTRL_FOUR]
							|| (!cmdByte[0] && ctrlReg[`FDC_CTRL_EXCH]);
					end
					3'h1: readCmd.track             <= cmdByte;
					3'h2: readCmd.head              <= cmdByte;
					3'h3: readCmd.sector            <= cmdByte;
					3'h4: readCmd.sizeCode          <= cmdByte;
					3'h5: readCmd.finalSectorNumber <= cmdByte;
					3'h6: readCmd.gap3              <= cmdByte;
					default: ; // Data length ignored
				endcase
			end
		end
	end

	// Sticky flag for unknown opcodes; a new error wins over a clear
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			invalidOpcode <= 1'b0;
		else if (cmdWrite && state == fdc_setup_pkg::CMD_IDLE
			&& cmdByte != `FDC_OP_PERP && cmdByte[4:0] != `FDC_OP_READ)
			invalidOpcode <= 1'b1;
		else if (clrErr)
			invalidOpcode <= 1'b0;
	end

	// Effective mode of the selected drive
	always_comb begin
		if (groupRecordingMode != 2'h0) begin
			effPerp = groupRecordingMode[0];
			effHigh = groupRecordingMode[1];
		end else begin
			effPerp = perDriveRecordingMode[readCmd.logicalDriveSelect];
			effHigh = ctrlReg[1:0] == `FDC_RATE_1M;
		end
	end

	// Gap figures follow mode changes one cycle later
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			gapInfo <= {1'b0, 1'b0, `FDC_GAP2_STD, `FDC_RW_NONE};
		end else begin
			gapInfo.perpendicular <= effPerp;
			gapInfo.precompZero   <= effPerp;
			gapInfo.gap2Length    <= (effPerp && effHigh)
				? `FDC_GAP2_PERP : `FDC_GAP2_STD;
			gapInfo.rewriteLength <= !effPerp ? `FDC_RW_NONE
				: effHigh ? `FDC_RW_HIGH : `FDC_RW_LOW;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	sequence sHighGroup;
		groupRecordingMode == 2'h3 ##1 groupRecordingMode == 2'h3;
	endsequence
	sequence sLastParam;
		cmdWrite && !swReset && paramIdx == `FDC_LAST_PARAM
			&& state == fdc_setup_pkg::CMD_READ_PARAM;
	endsequence

	a_soft_reset_group: assert property (
		swReset |=> groupRecordingMode == 2'h0)
		else $error("group field survived software reset");
	a_per_drive_kept: assert property (
		swReset |=> $stable(perDriveRecordingMode))
		else $error("per-drive bits changed on software reset");
	a_gate_off_hold: assert property (
		perpByte && !cmdByte[7] |=> $stable(perDriveRecordingMode))
		else $error("per-drive bits changed with gate clear");
	a_gate_on_apply: assert property (
		perpByte && !swReset && cmdByte[7] && cmdByte[1:0] == 2'h0
		|=> perDriveRecordingMode == $past(cmdByte[5:2]))
		else $error("per-drive bits not applied");
	a_group_high_gap: assert property (
		sHighGroup |-> gapInfo.gap2Length == `FDC_GAP2_PERP
		&& gapInfo.rewriteLength == `FDC_RW_HIGH)
		else $error("high rate group gaps wrong");
	a_format_gap_std: assert property (
		!(effPerp && effHigh) |=> gapInfo.gap2Length == `FDC_GAP2_STD)
		else $error("format gap 2 not 22");
	a_rewrite_conv: assert property (
		!effPerp |=> gapInfo.rewriteLength == `FDC_RW_NONE
		&& !gapInfo.precompZero)
		else $error("conventional rewrite not zero");
	a_precomp_perp: assert property (
		effPerp && !effHigh |=> gapInfo.precompZero
		&& gapInfo.rewriteLength == `FDC_RW_LOW)
		else $error("perpendicular precomp or rewrite wrong");
	a_perp_no_result: assert property (
		perpByte && !swReset |=> state == fdc_setup_pkg::CMD_IDLE)
		else $error("mode command did not return to idle");
	a_read_opcode: assert property (
		cmdWrite && !swReset && state == fdc_setup_pkg::CMD_IDLE
		&& cmdByte[4:0] == `FDC_OP_READ
		|=> state == fdc_setup_pkg::CMD_READ_PARAM)
		else $error("read opcode not recognised");
	a_length_ignored: assert property (
		sLastParam |=> state == fdc_setup_pkg::CMD_PRE_DELAY
		&& $stable(readCmd))
		else $error("data length byte stored or delay missed");
	a_head_inverse: assert property (
		cmdWrite && !swReset && paramIdx == 3'h0
		&& state == fdc_setup_pkg::CMD_READ_PARAM
		|=> headSideOutput_n == !$past(cmdByte[2]))
		else $error("head side output not inverse");
	a_delay_start: assert property (
		executeStart |-> $past(state) == fdc_setup_pkg::CMD_PRE_DELAY
		&& $past(delayCount) == 24'h000000)
		else $error("start without full delay");
	a_seek_start: assert property (
		seekStart |-> executeStart && readCmd.automaticSeekEnable)
		else $error("seek without request");

endmodule

// [logic/fdc_setup_cfg.svh]
`ifndef FDC_SETUP_CFG_SVH
`define FDC_SETUP_CFG_SVH

// Register byte offsets
`define FDC_OFF_CMD      12'h000
`define FDC_OFF_STATUS   12'h004
`define FDC_OFF_MODE     12'h008
`define FDC_OFF_PARAM0   12'h00c
`define FDC_OFF_PARAM1   12'h010
`define FDC_OFF_CTRL     12'h014
`define FDC_OFF_GAP      12'h018

// Control register fields
`define FDC_CTRL_RATE_HI 1
`define FDC_CTRL_RATE_LO 0
`define FDC_CTRL_FOUR    2
`define FDC_CTRL_EXCH    3
`define FDC_CTRL_SRST    4
`define FDC_CTRL_CLRERR  5
`define FDC_CTRL_RESET   4'h0

// Command encodings
`define FDC_OP_PERP      8'h12
`define FDC_OP_READ      5'h06
`define FDC_LAST_PARAM   3'h7

// Gap figures in bytes, and the 1M data rate code
`define FDC_GAP2_STD     6'h16
`define FDC_GAP2_PERP    6'h29
`define FDC_RW_NONE      6'h00
`define FDC_RW_LOW       6'h13
`define FDC_RW_HIGH      6'h26
`define FDC_RATE_1M      2'h3

// Delay before processing
`define FDC_PRE_DELAY_US     1000
`define FDC_CLK_MHZ          25
`define FDC_PRE_DELAY_CYCLES (`FDC_PRE_DELAY_US * `FDC_CLK_MHZ)

// Bus answers
`define FDC_RESP_OKAY    2'h0
`define FDC_RESP_SLVERR  2'h2

`endif

// [logic/fdc_setup_pkg.sv]
package fdc_setup_pkg;

	typedef enum logic [1:0] {
		CMD_IDLE,
		CMD_PERP_PARAM,
		CMD_READ_PARAM,
		CMD_PRE_DELAY
	} cmdState_t;

	typedef struct packed {
		logic       continueToSecondSide;
		logic       doubleDensityEncoding;
		logic       skipDeletedSectors;
		logic       automaticSeekEnable;
		logic       headSideBit;
		logic [1:0] logicalDriveSelect;
		logic [7:0] track;
		logic [7:0] head;
		logic [7:0] sector;
		logic [7:0] sizeCode;
		logic [7:0] finalSectorNumber;
		logic [7:0] gap3;
	} readCmd_t;

	typedef struct packed {
		logic       perpendicular;
		logic       precompZero;
		logic [5:0] gap2Length;
		logic [5:0] rewriteLength;
	} gapInfo_t;

endpackage

// [verification/fdc_perp_read_setup_tb.sv]
`timescale 1ns/100ps
`include "fdc_setup_cfg.svh"

module fdc_perp_read_setup_tb;
	localparam int unsigned PRE = 4;
	localparam int unsigned LIMIT = 5000;

	typedef struct packed {
		logic [7:0]  param;
		logic [1:0]  rate;
		logic [6:0]  mode;
		logic [13:0] gap;
	} modeRow_t;
	typedef struct packed {
		logic [7:0] op;
		logic [7:0] dh;
		logic [3:0] ctrl;
		logic       valid;
	} readRow_t;

	// Mode byte, data rate, expected mode and gap registers
	localparam modeRow_t MODE_ROWS [7] = '{
		'{8'h01, 2'h0, 7'h41, 14'h34d6},
		'{8'h03, 2'h3, 7'h43, 14'h39a9},
		'{8'h02, 2'h0, 7'h02, 14'h0016},
		'{8'h84, 2'h3, 7'h44, 14'h39a9},
		'{8'h00, 2'h3, 7'h44, 14'h39a9},
		'{8'h80, 2'h0, 7'h00, 14'h0016},
		'{8'h84, 2'h0, 7'h44, 14'h34d6}
	};
	// Opcode, drive/head byte, control value, drive code accepted
	localparam readRow_t READ_ROWS [4] = '{
		'{8'he6, 8'h86, 4'h8, 1'b1},
		'{8'h06, 8'h03, 4'h0, 1'b0},
		'{8'h46, 8'h01, 4'h0, 1'b1},
		'{8'h26, 8'h07, 4'h4, 1'b1}
	};

	logic                    clk = 1'b0;
	logic                    reset_n = 1'b0;
	logic                    awvalid, awready, wvalid, wready, bvalid, bready;
	logic                    arvalid, arready, rvalid, rready;
	logic [11:0]             awaddr, araddr;
	logic [31:0]             wdata, rdata, rd;
	logic [3:0]              wstrb;
	logic [1:0]              bresp, rresp, resp;
	fdc_setup_pkg::readCmd_t readCmd;
	fdc_setup_pkg::gapInfo_t gapInfo;
	logic                    driveSelectValid, headSideOutput_n;
	logic                    executeStart, seekStart;
	int                      num_errors = 0;
	int                      compares = 0;
	int                      cycles = 0;

	// 25 MHz clock
	always #20 clk = ~clk;

	fdc_perp_read_setup #(.PRE_DELAY_CYCLES(PRE)) dut_u (.clk, .reset_n,
		.awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb,
		.bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid,
		.rready, .rdata, .rresp, .readCmd, .gapInfo, .driveSelectValid,
		.headSideOutput_n, .executeStart, .seekStart);

	host_bus_model host_u (.clk, .awvalid, .awready, .awaddr, .wvalid,
		.wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid,
		.arready, .araddr, .rvalid, .rready, .rdata, .rresp);

	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		compares++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic end_of_test();
		$display("Compares %0d, mismatches %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic regWr(input logic [11:0] a, input logic [7:0] d);
		host_u.busWrite(a, {24'h0, d}, resp);
	endtask

	task automatic regRd(input logic [11:0] a);
		host_u.busRead(a, rd, resp);
	endtask

	// Outputs and mode bits straight after a hardware reset
	task automatic checkIdle();
		@(negedge clk);
		check(gapInfo, {2'b00, 6'h16, 6'h00});
		check(readCmd, 64'h0);
		check(headSideOutput_n, 1'b1);
		regRd(`FDC_OFF_MODE);
		check(rd[5:0], 6'h00);
	endtask

	// Hang guard, far above the few hundred cycles the run needs
	always @(posedge clk) begin
		cycles++;
		if (cycles == LIMIT) begin
			num_errors++;
			end_of_test();
		end
	end

	// Main sequence
	initial begin
		int n;
		modeRow_t m;
		readRow_t r;
		fdc_setup_pkg::readCmd_t e;
		repeat (12) @(posedge clk);
		reset_n <= 1'b1;
		checkIdle();
		$display("Reset test done");
		foreach (MODE_ROWS[i]) begin
			m = MODE_ROWS[i];
			regWr(`FDC_OFF_CTRL, {6'h0, m.rate});
			regWr(`FDC_OFF_CMD, `FDC_OP_PERP);
			regWr(`FDC_OFF_CMD, m.param);
			regRd(`FDC_OFF_MODE);
			check(rd[6:0], m.mode);
			regRd(`FDC_OFF_GAP);
			check(rd[13:0], m.gap);
			check(gapInfo, {m.gap[12], m.gap[13], m.gap[5:0], m.gap[11:6]});
		end
		regRd(`FDC_OFF_STATUS);
		check(rd[0], 1'b0);
		$display("Mode table test done");
		// Drive select code, flags and head side per command
		foreach (READ_ROWS[i]) begin
			r = READ_ROWS[i];
			regWr(`FDC_OFF_CTRL, {4'h0, r.ctrl});
			e = {r.op[7:5], r.dh[7], r.dh[2], r.dh[1:0], 8'h4f,
				{7'h0, r.dh[2]}, 8'h01, 8'h02, 8'h12, 8'h1b};
			host_u.sendRead({r.op, r.dh, 8'h4f, {7'h0, r.dh[2]}, 8'h01,
				8'h02, 8'h12, 8'h1b});
			n = 0;
			while (executeStart !== 1'b1 && n < 20) begin
				@(negedge clk);
				n++;
			end
			check(executeStart, 1'b1);
			check(n >= PRE, 1'b1);
			check(seekStart, r.dh[7]);
			check(readCmd, e);
			check(driveSelectValid, r.valid);
			check(headSideOutput_n, !r.dh[2]);
			@(negedge clk);
			check(executeStart, 1'b0);
		end
		$display("Read command test done");
		// Software reset drops the group field but keeps drive bits
		regWr(`FDC_OFF_CMD, `FDC_OP_PERP);
		regWr(`FDC_OFF_CMD, 8'h88);
		regWr(`FDC_OFF_CMD, `FDC_OP_PERP);
		regWr(`FDC_OFF_CMD, 8'h01);
		regWr(`FDC_OFF_CTRL, 8'h10);
		regRd(`FDC_OFF_MODE);
		check(rd[5:0], 6'h08);
		$display("Software reset test done");
		// Unmapped place refused both ways
		regRd(12'h100);
		check(resp, `FDC_RESP_SLVERR);
		regWr(12'h100, 8'h00);
		check(resp, `FDC_RESP_SLVERR);
		$display("Unmapped address test done");
		// Unknown opcode raises the sticky flag; the clear pulse drops it
		regWr(`FDC_OFF_CMD, 8'h00);
		check(resp, `FDC_RESP_OKAY);
		regRd(`FDC_OFF_STATUS);
		check(rd[6], 1'b1);
		regWr(`FDC_OFF_CTRL, 8'h20);
		regRd(`FDC_OFF_STATUS);
		check(rd[6], 1'b0);
		$display("Invalid opcode test done");
		// Second hardware reset clears the kept drive bits as well
		@(posedge clk);
		reset_n <= 1'b0;
		repeat (2) @(posedge clk);
		reset_n <= 1'b1;
		checkIdle();
		$display("Hardware reset test done");
		end_of_test();
	end
endmodule

// [verification/host_bus_model.sv]
`timescale 1ns/100ps
`include "fdc_setup_cfg.svh"

// Processor side of the register bus, one write or one read at a time
module host_bus_model (
	input  wire logic        clk,
	output logic             awvalid,
	input  wire logic        awready,
	output logic [11:0]      awaddr,
	output logic             wvalid,
	input  wire logic        wready,
	output logic [31:0]      wdata,
	output logic [3:0]       wstrb,
	input  wire logic        bvalid,
	output logic             bready,
	input  wire logic [1:0]  bresp,
	output logic             arvalid,
	input  wire logic        arready,
	output logic [11:0]      araddr,
	input  wire logic        rvalid,
	output logic             rready,
	input  wire logic [31:0] rdata,
	input  wire logic [1:0]  rresp
);
	// Quiet bus at time zero
	initial begin
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		awaddr = 12'h000;
		araddr = 12'h000;
		wdata = 32'h00000000;
		wstrb = 4'h0;
	end

	// Address and data offered together, each released once taken
	task automatic busWrite(input logic [11:0] a, input logic [31:0] d,
			output logic [1:0] resp);
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'h1;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		forever begin
			@(posedge clk);
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready) begin
				wvalid <= 1'b0;
				wdata <= ~d; // Stale data must not look valid
			end
			if (bready && bvalid) begin
				resp = bresp;
				bready <= 1'b0;
				break;
			end
		end
	endtask

	// Read held until the answer is sampled
	task automatic busRead(input logic [11:0] a, output logic [31:0] d,
			output logic [1:0] resp);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever begin
			@(posedge clk);
			if (arvalid && arready)
				arvalid <= 1'b0;
			if (rready && rvalid) begin
				d = rdata;
				resp = rresp;
				rready <= 1'b0;
				break;
			end
		end
	endtask

	// Opcode and seven fields, then the obsolete length of all ones
	task automatic sendRead(input logic [63:0] b);
		logic [1:0] resp;
		for (int i = 7; i >= 0; i--)
			busWrite(`FDC_OFF_CMD, {24'h0, b[i*8+:8]}, resp);
		busWrite(`FDC_OFF_CMD, 32'h000000ff, resp);
	endtask
endmodule
